// >>> common/art_regs.svh
`ifndef ART_REGS_SVH
`define ART_REGS_SVH
// register indices, byte address is four times the index
`define ART_IDX_DUTY3     8'h31
`define ART_IDX_DUTY2     8'h32
`define ART_IDX_DUTY1     8'h33
`define ART_IDX_DUTY0     8'h34
`define ART_IDX_PWMCTL    8'h35
`define ART_IDX_CSR       8'h36
`define ART_IDX_CAR       8'h37
`define ART_IDX_RELOAD    8'h38
`define ART_IDX_CAPCS     8'h39
`define ART_IDX_CAP1      8'h3A
`define ART_IDX_CAP2      8'h3B
// timer_control_status fields
`define ART_CSR_SRC       7
`define ART_CSR_TAP_HI    6
`define ART_CSR_TAP_LO    4
`define ART_CSR_RUN       3
`define ART_CSR_FRL       2
`define ART_CSR_OIE       1
`define ART_CSR_OVF       0
// pwm_output_control fields
`define ART_PWM_OE_HI     7
`define ART_PWM_OE_LO     4
`define ART_PWM_OP_HI     3
`define ART_PWM_OP_LO     0
// capture_control_status fields
`define ART_CAP_SEL_LO    4
`define ART_CAP_IE_LO     2
`define ART_CAP_FLG_LO    0
// reset values and counts
`define ART_RST_BYTE      8'h00
`define ART_CNT_TOP       8'hFF
`define ART_PRE_RST       7'h00
`endif

// >>> common/art_pkg.sv
`default_nettype none
package art_pkg;
    typedef logic [7:0] art_byte_t;
    typedef enum logic {
        ART_SRC_CPU,
        ART_SRC_EXT
    } art_src_t;
endpackage : art_pkg
`default_nettype wire

// >>> verilog/art_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "art_regs.svh"
module art_prescaler
    import art_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // control
    input  wire logic       inTick,
    input  wire logic       clear,
    input  wire logic [2:0] tapSel,
    // result
    output logic            cntTick
);
    logic [6:0] pre_r;
    logic [6:0] tapMask;

    function automatic logic [6:0] tap_mask(input logic [2:0] n);
        tap_mask = 7'((8'h01 << n) - 8'h01);
    endfunction : tap_mask

    assign tapMask = tap_mask(tapSel);
    assign cntTick = inTick && ((pre_r & tapMask) == tapMask);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pre_r <= `ART_PRE_RST;
        end else if (clear) begin
            pre_r <= `ART_PRE_RST;
        end else if (inTick) begin
            pre_r <= pre_r + 7'h01;
        end
    end
endmodule : art_prescaler
`default_nettype wire

// >>> verilog/art_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "art_regs.svh"
module art_capture
    import art_pkg::*;
(
    // clock and reset
    input  wire logic     clk_sys,
    input  wire logic     reset,
    // pin and control
    input  wire logic     capPin,
    input  wire logic     edgeRise,
    input  wire logic     haltMode,
    input  wire art_byte_t counterVal,
    input  wire logic     readClr,
    // state
    output art_byte_t     capValue_r,
    output logic          capFlag_r,
    output logic          wakeEdge
);
    logic syncA_r;
    logic syncB_r;
    logic syncC_r;
    logic pinPrev_r;
    logic capEdge;

    // two-stage synchroniser, then edge detect on the settled copy
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
            syncC_r <= 1'b0;
        end else begin
            syncA_r <= capPin;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
        end
    end

    assign capEdge = edgeRise ? (syncB_r & ~syncC_r) : (~syncB_r & syncC_r);

    // direct pin edge for wake-up while halted
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinPrev_r <= 1'b0;
        end else begin
            pinPrev_r <= capPin;
        end
    end

    assign wakeEdge = haltMode && (edgeRise ? (capPin & ~pinPrev_r) : (~capPin & pinPrev_r));

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            capValue_r <= `ART_RST_BYTE;
        end else if (capEdge && !capFlag_r && !haltMode) begin
            capValue_r <= counterVal;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            capFlag_r <= 1'b0;
        end else if (capEdge && !haltMode) begin
            capFlag_r <= 1'b1;
        end else if (readClr) begin
            capFlag_r <= 1'b0;
        end
    end

    property p_cap_hold;
        @(posedge clk_sys) disable iff (reset)
        capFlag_r && !readClr |=> $stable(capValue_r) && capFlag_r;
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture value changed while flagged");

    property p_cap_load;
        @(posedge clk_sys) disable iff (reset)
        capEdge && !capFlag_r && !haltMode |=> capFlag_r && capValue_r == $past(counterVal);
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture not latched on edge");

    property p_cap_halt;
        @(posedge clk_sys) disable iff (reset)
        haltMode |=> $stable(capValue_r);
    endproperty
    a_cap_halt: assert property (p_cap_halt) else $error("capture loaded during halt");
endmodule : art_capture
`default_nettype wire

// >>> verilog/art_timer_top.sv
// Operation
// - seven-bit prescaler, three-bit tap select divides input by two to the n
// - source select 0 uses the cpu clock, 1 the external clock input
// - run enable clear freezes prescaler and counter; set lets the counter advance
// - reset clears counter and prescaler and selects the cpu clock
// - past FFh the counter reloads from reload value, prescaler untouched, overflow
// - force reload is write-only, reads zero, loads counter and clears prescaler
// - counter access reads the live count; a write loads it and clears prescaler
// - four hidden compare values copied from duty values at every overflow outside halt
// - all channels share a period of 256 minus reload value ticks
// - at overflow each pwm output takes the level set by its polarity bit
// - counter equal to compare value returns the output to the opposite level
// - each channel output enable independently drives its pin push-pull
// - pwm generation stops while the part is halted
// - overflow sets flag, raises interrupt if enabled; status read clears flag
// - on external clock the flag sets after 256 minus reload value events, times two to the n
// - programmed capture edge copies counter into capture value and sets flag
// - capture value is held until read; that read clears the capture flag
// - capture request stays high while capture flag and its enable are set
// - capture inputs pass two flip-flops before latching the counter
// - halt blocks capture loading; enabled pin edge still raises a wake-up
// - counter advances by one on each prescaler output tick
// - edge select 0 captures on falling edge, 1 on rising edge
// - a polarity change inverts the channel output at the next clock edge
`timescale 1ns/1ps
`default_nettype none
`include "art_regs.svh"
module art_timer_top
    import art_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system and link pins
    input  wire logic        haltMode,
    input  wire logic        external_input_clock,
    input  wire logic [1:0]  capture_input_pin,
    // outputs
    output logic [3:0]       pwm_output_pin,
    output logic [3:0]       pwmOe,
    output logic             ovfIrq,
    output logic [1:0]       capIrq,
    output logic             wakeIrq
);
    // software registers
    art_src_t   srcSel_r;
    logic [2:0] tapSel_r;
    logic       runEn_r;
    logic       ovfIe_r;
    logic       ovfFlag_r;
    art_byte_t  reload_r;
    art_byte_t  cnt_r;
    art_byte_t  duty_r [4];
    art_byte_t  cmp_r [4];
    logic [3:0] oe_r;
    logic [3:0] pol_r;
    logic [1:0] capSel_r;
    logic [1:0] capIe_r;
    logic [3:0] phase_r;
    logic       extPrev_r;
    // bus state
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [3:0]  pwmOut_r;
    logic [3:0]  pwmOe_r;
    logic        ovfIrq_r;
    logic [1:0]  capIrq_r;
    logic        wakeIrq_r;
    // internal nets
    logic        access;
    logic        wrEn;
    logic        rdEn;
    logic [9:0]  regIdx;
    logic        addrOk;
    art_byte_t   rdByte;
    logic        inTick;
    logic        cntTick;
    logic        extRise;
    logic        swLoad;
    logic        forceLoad;
    logic        carWrite;
    logic        ovfEvent;
    art_byte_t   capValue [2];
    logic [1:0]  capFlag;
    logic [1:0]  wakeEdge;
    logic [1:0]  capRdClr;

    function automatic logic is_reg(input logic [9:0] idx, input logic [7:0] want);
        is_reg = (idx == {2'b00, want});
    endfunction : is_reg

    function automatic logic known_idx(input logic [9:0] idx);
        known_idx = (idx >= {2'b00, `ART_IDX_DUTY3}) && (idx <= {2'b00, `ART_IDX_CAP2});
    endfunction : known_idx

    // apb decode: one wait-free access phase, answered from registered pready
    assign regIdx = paddr[11:2];
    assign addrOk = known_idx(regIdx) && (paddr[1:0] == 2'b00);
    assign access = psel && penable && pready_r;
    assign wrEn   = access && pwrite && addrOk;
    assign rdEn   = access && !pwrite && addrOk;

    assign carWrite  = wrEn && is_reg(regIdx, `ART_IDX_CAR);
    assign forceLoad = wrEn && is_reg(regIdx, `ART_IDX_CSR) && pwdata[`ART_CSR_FRL];
    assign swLoad    = carWrite || forceLoad;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !known_idx(regIdx)
                         || psel && !penable && (paddr[1:0] != 2'b00);
        end
    end

    // read mux
    always_comb begin
        rdByte = `ART_RST_BYTE;
        unique case (regIdx[7:0])
            `ART_IDX_DUTY3:  rdByte = duty_r[3];
            `ART_IDX_DUTY2:  rdByte = duty_r[2];
            `ART_IDX_DUTY1:  rdByte = duty_r[1];
            `ART_IDX_DUTY0:  rdByte = duty_r[0];
            `ART_IDX_PWMCTL: rdByte = {oe_r, pol_r};
            `ART_IDX_CSR:    rdByte = {srcSel_r == ART_SRC_EXT, tapSel_r, runEn_r, 1'b0,
                                      ovfIe_r, ovfFlag_r};
            `ART_IDX_CAR:    rdByte = cnt_r;
            `ART_IDX_RELOAD: rdByte = reload_r;
            `ART_IDX_CAPCS:  rdByte = {2'b00, capSel_r, capIe_r, capFlag};
            `ART_IDX_CAP1:   rdByte = capValue[0];
            `ART_IDX_CAP2:   rdByte = capValue[1];
            default:         rdByte = `ART_RST_BYTE;
        endcase
        if (regIdx[9:8] != 2'b00) begin
            rdByte = `ART_RST_BYTE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_r <= {24'h00_0000, rdByte};
        end
    end

    // control/status and configuration writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            srcSel_r <= ART_SRC_CPU;
            tapSel_r <= 3'h0;
            runEn_r  <= 1'b0;
            ovfIe_r  <= 1'b0;
        end else if (wrEn && is_reg(regIdx, `ART_IDX_CSR)) begin
            srcSel_r <= pwdata[`ART_CSR_SRC] ? ART_SRC_EXT : ART_SRC_CPU;
            tapSel_r <= pwdata[`ART_CSR_TAP_HI:`ART_CSR_TAP_LO];
            runEn_r  <= pwdata[`ART_CSR_RUN];
            ovfIe_r  <= pwdata[`ART_CSR_OIE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reload_r <= `ART_RST_BYTE;
            oe_r     <= 4'h0;
            pol_r    <= 4'h0;
            capSel_r <= 2'h0;
            capIe_r  <= 2'h0;
        end else if (wrEn) begin
            if (is_reg(regIdx, `ART_IDX_RELOAD)) begin
                reload_r <= pwdata[7:0];
            end
            if (is_reg(regIdx, `ART_IDX_PWMCTL)) begin
                oe_r  <= pwdata[`ART_PWM_OE_HI:`ART_PWM_OE_LO];
                pol_r <= pwdata[`ART_PWM_OP_HI:`ART_PWM_OP_LO];
            end
            if (is_reg(regIdx, `ART_IDX_CAPCS)) begin
                capSel_r <= pwdata[`ART_CAP_SEL_LO+1:`ART_CAP_SEL_LO];
                capIe_r  <= pwdata[`ART_CAP_IE_LO+1:`ART_CAP_IE_LO];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                duty_r[i] <= `ART_RST_BYTE;
            end
        end else if (wrEn) begin
            for (int i = 0; i < 4; i++) begin
                if (is_reg(regIdx, 8'(`ART_IDX_DUTY0 - i))) begin
                    duty_r[i] <= pwdata[7:0];
                end
            end
        end
    end

    // input clock selection; external path is dead during halt
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            extPrev_r <= 1'b0;
        end else begin
            extPrev_r <= external_input_clock;
        end
    end

    assign extRise = external_input_clock && !extPrev_r;
    assign inTick  = runEn_r && !swLoad
                     && ((srcSel_r == ART_SRC_CPU) || (extRise && !haltMode));

    art_prescaler u_prescaler (
        .clk_sys (clk_sys),
        .reset   (reset),
        .inTick  (inTick),
        .clear   (swLoad),
        .tapSel  (tapSel_r),
        .cntTick (cntTick)
    );

    // counter with auto-reload
    assign ovfEvent = cntTick && (cnt_r == `ART_CNT_TOP);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= `ART_RST_BYTE;
        end else if (carWrite) begin
            cnt_r <= pwdata[7:0];
        end else if (forceLoad) begin
            cnt_r <= reload_r;
        end else if (ovfEvent) begin
            cnt_r <= reload_r;
        end else if (cntTick) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // overflow flag: set wins over the read that clears it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovfFlag_r <= 1'b0;
        end else if (ovfEvent) begin
            ovfFlag_r <= 1'b1;
        end else if (rdEn && is_reg(regIdx, `ART_IDX_CSR)) begin
            ovfFlag_r <= 1'b0;
        end
    end

    // compare shadow and pwm phase, frozen in halt
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                cmp_r[i] <= `ART_RST_BYTE;
            end
            phase_r <= 4'h0;
        end else if (!haltMode) begin
            for (int i = 0; i < 4; i++) begin
                if (ovfEvent) begin
                    cmp_r[i]   <= duty_r[i];
                    phase_r[i] <= 1'b1;
                end else if (cnt_r == cmp_r[i]) begin
                    phase_r[i] <= 1'b0;
                end
            end
        end
    end

    // output pins: polarity applied combinationally so a change shows next edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwmOut_r <= 4'h0;
            pwmOe_r  <= 4'h0;
        end else begin
            pwmOut_r <= oe_r & (phase_r ^ pol_r);
            pwmOe_r  <= oe_r;
        end
    end

    // capture channels
    for (genvar c = 0; c < 2; c++) begin : g_cap
        assign capRdClr[c] = rdEn && is_reg(regIdx, 8'(`ART_IDX_CAP1 + c));
        art_capture u_capture (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .capPin     (capture_input_pin[c]),
            .edgeRise   (capSel_r[c]),
            .haltMode   (haltMode),
            .counterVal (cnt_r),
            .readClr    (capRdClr[c]),
            .capValue_r (capValue[c]),
            .capFlag_r  (capFlag[c]),
            .wakeEdge   (wakeEdge[c])
        );
    end

    // interrupt requests
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovfIrq_r  <= 1'b0;
            capIrq_r  <= 2'h0;
            wakeIrq_r <= 1'b0;
        end else begin
            ovfIrq_r  <= ovfFlag_r && ovfIe_r;
            capIrq_r  <= capFlag & capIe_r;
            wakeIrq_r <= |(wakeEdge & capIe_r);
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign pwm_output_pin = pwmOut_r;
    assign pwmOe          = pwmOe_r;
    assign ovfIrq         = ovfIrq_r;
    assign capIrq         = capIrq_r;
    assign wakeIrq        = wakeIrq_r;

    // checks
    property p_reload;
        @(posedge clk_sys) disable iff (reset)
        ovfEvent && !swLoad |=> cnt_r == $past(reload_r) && ovfFlag_r;
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload");

    property p_stop;
        @(posedge clk_sys) disable iff (reset)
        !runEn_r && !swLoad |=> $stable(cnt_r);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_carwrite;
        @(posedge clk_sys) disable iff (reset)
        carWrite |=> cnt_r == $past(pwdata[7:0]);
    endproperty
    a_carwrite: assert property (p_carwrite) else $error("counter write lost");

    property p_frl_zero;
        @(posedge clk_sys) disable iff (reset)
        psel && !penable && !pwrite && is_reg(regIdx, `ART_IDX_CSR)
            |=> prdata_r[`ART_CSR_FRL] == 1'b0;
    endproperty
    a_frl_zero: assert property (p_frl_zero) else $error("force reload read as one");

    property p_incr;
        @(posedge clk_sys) disable iff (reset)
        cntTick && !swLoad && cnt_r != `ART_CNT_TOP |=> cnt_r == $past(cnt_r) + 8'h01;
    endproperty
    a_incr: assert property (p_incr) else $error("counter did not advance");

    property p_shadow;
        @(posedge clk_sys) disable iff (reset)
        ovfEvent && !haltMode |=> cmp_r[0] == $past(duty_r[0]) && phase_r[0];
    endproperty
    a_shadow: assert property (p_shadow) else $error("compare not copied at overflow");

    property p_pol;
        @(posedge clk_sys) disable iff (reset)
        oe_r[0] |=> pwmOut_r[0] == ($past(phase_r[0]) ^ $past(pol_r[0]));
    endproperty
    a_pol: assert property (p_pol) else $error("pwm level wrong");

    property p_ovf_irq;
        @(posedge clk_sys) disable iff (reset)
        ovfEvent && ovfIe_r ##1 ovfIe_r |=> ovfIrq_r;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

    property p_cap_irq;
        @(posedge clk_sys) disable iff (reset)
        capFlag[0] && capIe_r[0] |=> capIrq_r[0];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture request dropped");

    c_overflow: cover property (@(posedge clk_sys) disable iff (reset) ovfEvent);
    c_capture: cover property (@(posedge clk_sys) disable iff (reset) $rose(capFlag[0]));
    c_wake: cover property (@(posedge clk_sys) disable iff (reset) wakeIrq_r);
    c_pwm_fall: cover property (@(posedge clk_sys) disable iff (reset) $fell(phase_r[1]));
endmodule : art_timer_top
`default_nettype wire

// >>> dv/art_partner.sv
`timescale 1ns/1ps
`default_nettype none
module art_partner (
    // clock
    input  wire logic       clk_sys,
    // event source and capture inputs
    output var  logic       extClk,
    output var  logic [1:0] capPin
);
    initial begin
        extClk = 1'b0;
        capPin = 2'h0;
    end
    // n events, clock idle low between them
    task automatic events(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            extClk <= 1'b1;
            @(posedge clk_sys);
            extClk <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask : events
    // drive one capture input to a level
    task automatic setPin(input int ch, input logic v);
        @(posedge clk_sys);
        capPin[ch] <= v;
    endtask : setPin
endmodule : art_partner
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "art_regs.svh"
module tb import art_pkg::*;;
    logic        clk_sys, reset, psel, penable, pwrite, haltMode, extClk;
    logic        pready, pslverr, ovfIrq, wakeIrq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  capPin, capIrq;
    logic [3:0]  pwm, pwmOe, p;
    logic [7:0]  q;
    wire  [7:0]  flags = {wakeIrq, capIrq, ovfIrq, pwm};
    int          n_fail, n_compared, per, hi, lo, k;
    art_timer_top i_dut (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .haltMode(haltMode), .external_input_clock(extClk), .capture_input_pin(capPin),
        .pwm_output_pin(pwm), .pwmOe(pwmOe), .ovfIrq(ovfIrq), .capIrq(capIrq),
        .wakeIrq(wakeIrq)
    );
    art_partner i_partner (.clk_sys(clk_sys), .extClk(extClk), .capPin(capPin));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_fail++;
            end_of_test();
        end
        q = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(q, e);
    endtask : rdc
    // wait for a flag bit to reach a level, bounded
    task automatic waitSig(input int b, input logic v);
        k = 0;
        while (flags[b] !== v) begin
            @(posedge clk_sys);
            k++;
            if (k > 5000) begin
                n_fail++;
                end_of_test();
            end
        end
    endtask : waitSig
    // period and high time of one pwm channel, in clocks
    task automatic measure(input int ch);
        waitSig(ch, 1'b0);
        waitSig(ch, 1'b1);
        hi = 1;
        per = 0;
        lo = 0;
        while (per < 5000) begin
            @(posedge clk_sys);
            per++;
            if (pwm[ch] === 1'b1 && lo != 0) break;
            if (pwm[ch] !== 1'b1) lo = 1;
            else hi++;
        end
    endtask : measure
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        haltMode = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 8'h31; i <= 8'h3B; i++) rdc(i[7:0], 8'h00);
        chk({pwm, pwmOe}, 8'h00);
        apb(1'b0, 8'h30, 8'h00);
        chk({err, q}, 9'h100);
        wr(`ART_IDX_RELOAD, 8'hF0);
        wr(`ART_IDX_CSR, 8'h04);
        rdc(`ART_IDX_CSR, 8'h00);
        rdc(`ART_IDX_CAR, 8'hF0);
        rdc(`ART_IDX_CAR, 8'hF0);
        wr(`ART_IDX_CAR, 8'hA5);
        rdc(`ART_IDX_CAR, 8'hA5);
        wr(`ART_IDX_DUTY0, 8'hF8);
        wr(`ART_IDX_DUTY1, 8'hF8);
        wr(`ART_IDX_DUTY2, 8'hF4);
        wr(`ART_IDX_PWMCTL, 8'h70);
        for (int n = 0; n < 8; n++) begin
            wr(`ART_IDX_CSR, {1'b0, n[2:0], 4'h8});
            measure(0);
            chk(per, 16 << n);
            // high from the reload count up to and including the compare clock
            chk(hi, (8 << n) + 1);
        end
        wr(`ART_IDX_CSR, 8'h0A);
        measure(2);
        chk(hi, 5);
        chk({pwm[3], pwmOe}, 5'h07);
        wr(`ART_IDX_PWMCTL, 8'h72);
        repeat (2) @(posedge clk_sys);
        lo = 0;
        repeat (64) begin
            @(posedge clk_sys);
            lo += (pwm[1] === pwm[0]);
        end
        chk(lo, 0);
        // long period so the flag clear cannot meet an overflow
        wr(`ART_IDX_CAR, 8'h00);
        apb(1'b0, `ART_IDX_CSR, 8'h00);
        waitSig(4, 1'b0);
        waitSig(4, 1'b1);
        rdc(`ART_IDX_CSR, 8'h0B);
        repeat (2) @(posedge clk_sys);
        chk(ovfIrq, 1'b0);
        wr(`ART_IDX_CSR, 8'h08);
        repeat (40) @(posedge clk_sys);
        chk(ovfIrq, 1'b0);
        rdc(`ART_IDX_CSR, 8'h09);
        wr(`ART_IDX_CSR, 8'h00);
        wr(`ART_IDX_RELOAD, 8'hFD);
        wr(`ART_IDX_CSR, 8'h84);
        apb(1'b0, `ART_IDX_CSR, 8'h00);
        wr(`ART_IDX_CSR, 8'h88);
        i_partner.events(2);
        rdc(`ART_IDX_CSR, 8'h88);
        i_partner.events(1);
        repeat (4) @(posedge clk_sys);
        rdc(`ART_IDX_CSR, 8'h89);
        wr(`ART_IDX_CSR, 8'h00);
        wr(`ART_IDX_CAR, 8'h55);
        wr(`ART_IDX_CAPCS, 8'h14);
        i_partner.setPin(0, 1'b1);
        waitSig(5, 1'b1);
        rdc(`ART_IDX_CAPCS, 8'h15);
        wr(`ART_IDX_CAR, 8'h66);
        i_partner.setPin(0, 1'b0);
        i_partner.setPin(0, 1'b1);
        repeat (6) @(posedge clk_sys);
        rdc(`ART_IDX_CAP1, 8'h55);
        repeat (2) @(posedge clk_sys);
        chk(capIrq, 2'h0);
        i_partner.setPin(0, 1'b0);
        i_partner.setPin(0, 1'b1);
        waitSig(5, 1'b1);
        rdc(`ART_IDX_CAP1, 8'h66);
        wr(`ART_IDX_CAPCS, 8'h08);
        i_partner.setPin(1, 1'b1);
        repeat (6) @(posedge clk_sys);
        chk(capIrq, 2'h0);
        i_partner.setPin(1, 1'b0);
        waitSig(6, 1'b1);
        rdc(`ART_IDX_CAP2, 8'h66);
        wr(`ART_IDX_RELOAD, 8'hF0);
        wr(`ART_IDX_CSR, 8'h08);
        wr(`ART_IDX_CAPCS, 8'h14);
        repeat (40) @(posedge clk_sys);
        // stop early in the high phase, then halt with the counter stopped
        waitSig(0, 1'b0);
        waitSig(0, 1'b1);
        wr(`ART_IDX_CSR, 8'h00);
        haltMode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        p = pwm;
        chk(p[0], 1'b1);
        // a compare hit while halted must not move the output
        wr(`ART_IDX_CAR, 8'hF8);
        lo = 0;
        repeat (100) begin
            @(posedge clk_sys);
            lo += (pwm !== p);
        end
        chk(lo, 0);
        i_partner.setPin(0, 1'b0);
        i_partner.setPin(0, 1'b1);
        waitSig(7, 1'b1);
        chk(capIrq, 2'h0);
        rdc(`ART_IDX_CAP1, 8'h66);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
